// ==== inc/uee_defs.svh ====
// Register offsets, field positions and reset values of the USB error/endpoint bank
`ifndef UEE_DEFS_SVH
`define UEE_DEFS_SVH
`define UEE_OFF_ERR_IE 8'h00
`define UEE_OFF_ERR_FLAG 8'h04
`define UEE_OFF_STATUS 8'h08
`define UEE_OFF_EP_BASE 8'h40
`define UEE_EP_COUNT 16
`define UEE_ERR_IE_MASK 8'hbf
`define UEE_EP0_MASK 8'hdf
`define UEE_EPN_MASK 8'h1f
`define UEE_BIT_LOWSPEED_DIRECT 7
`define UEE_BIT_RETRY_OFF 6
`define UEE_BIT_CTRL_BLOCK 4
`define UEE_BIT_RX_EN 3
`define UEE_BIT_TX_EN 2
`define UEE_BIT_STALLED 1
`define UEE_BIT_HSHK 0
`define UEE_ERR_BITSTUFF 7
`define UEE_ERR_DMA 5
`define UEE_ERR_TURNAROUND 4
`define UEE_ERR_PARTIAL 3
`define UEE_ERR_DATA_CRC 2
`define UEE_ERR_TOKEN_EOF 1
`define UEE_ERR_PID 0
`define UEE_RESET_BYTE 8'h00
`define UEE_BAD_READ 32'hdeadbeef
`endif

// ==== inc/uee_pkg.sv ====
// Types shared by the USB error/endpoint register bank
package uee_pkg;
	typedef struct packed {
		logic lowspeed_direct;
		logic nak_retry_off;
		logic ctrl_xfer_block;
		logic ep_rx_en_a;
		logic ep_tx_en_b;
		logic ep_stalled;
		logic ep_handshake_en;
	} uee_ep_ctrl_t;

	typedef struct packed {
		logic rx_ok;
		logic tx_ok;
		logic setup_ok;
		logic handshake;
		logic stalled;
	} uee_ep_perm_t;

	typedef enum logic [1:0] {
		UEE_IDLE = 2'b00,
		UEE_ANSWER = 2'b01
	} uee_bus_state_t;
endpackage

// ==== hdl/uee_ep_decode.sv ====
// Per-endpoint permission decode from one endpoint control byte
`timescale 1ns/1ps
`include "uee_defs.svh"
module uee_ep_decode
	import uee_pkg::*;
(
	input wire logic [7:0] ctrl_in, // Endpoint control byte
	output uee_ep_perm_t perm_out // Decoded permissions
);
	assign perm_out.rx_ok = ctrl_in[`UEE_BIT_RX_EN];
	assign perm_out.tx_ok = ctrl_in[`UEE_BIT_TX_EN];
	assign perm_out.setup_ok = ctrl_in[`UEE_BIT_RX_EN] &
		ctrl_in[`UEE_BIT_TX_EN] & ~ctrl_in[`UEE_BIT_CTRL_BLOCK];
	assign perm_out.handshake = ctrl_in[`UEE_BIT_HSHK];
	assign perm_out.stalled = ctrl_in[`UEE_BIT_STALLED];
endmodule

// ==== hdl/uee_regs.sv ====
// USB error interrupt enable and endpoint control register bank
`timescale 1ns/1ps
`include "uee_defs.svh"
module uee_regs
	import uee_pkg::*;
#(
	parameter int EP_COUNT = `UEE_EP_COUNT
) (
	input wire logic core_clk_in, // Controller clock, 200 MHz
	input wire logic rst_n_in, // Asynchronous reset, active low
	input wire logic [7:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Byte enables
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall until answer
	input wire logic host_role_in, // High in host role
	input wire logic [7:0] err_event_in, // Error detect pulses
	input wire logic [3:0] stall_ep_in, // Endpoint that got stalled
	input wire logic stall_evt_in, // Stall event pulse
	input wire logic [10:0] rx_count_in, // Received byte count
	input wire logic [10:0] bd_count_in, // Descriptor byte count
	input wire logic rx_done_in, // Receive packet finished pulse
	output logic usb_err_irq_out, // Error interrupt request
	output logic lowspeed_direct_out, // Low-speed direct connect
	output logic nak_retry_off_out, // Hardware NAK retry off
	output logic truncate_out, // Truncate stored data
	output logic [EP_COUNT-1:0] rx_ok_out, // Receive allowed
	output logic [EP_COUNT-1:0] tx_ok_out, // Transmit allowed
	output logic [EP_COUNT-1:0] setup_ok_out, // SETUP allowed
	output logic [EP_COUNT-1:0] hshk_out // Handshake enabled
);
	logic [7:0] err_ie_reg;
	logic [7:0] err_flag_reg;
	logic [7:0] ep_reg [EP_COUNT];
	uee_ep_perm_t perm [EP_COUNT];
	uee_bus_state_t state_reg;
	logic full_word;
	logic wr_take;
	logic [7:0] flag_set;
	logic oversize;
	logic [EP_COUNT-1:0] ep_wr_sel;
	logic [EP_COUNT-1:0] stall_sel;

	function automatic logic [7:0] ep_mask(input int idx, input logic host);
		ep_mask = (idx == 0 && host) ? `UEE_EP0_MASK : `UEE_EPN_MASK;
	endfunction

	// Byte address of an endpoint's control word
	function automatic logic [7:0] ep_addr(input int idx);
		ep_addr = `UEE_OFF_EP_BASE + 8'(4 * idx);
	endfunction

	function automatic logic is_ep(input logic [7:0] a);
		is_ep = a >= `UEE_OFF_EP_BASE && a < ep_addr(EP_COUNT) &&
			a[1:0] == 2'b00;
	endfunction

	// Avalon answers one cycle after the request is seen
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= UEE_IDLE;
		end else begin
			case (state_reg)
				UEE_IDLE: begin
					if (avs_read_in || avs_write_in) begin
						state_reg <= UEE_ANSWER;
					end
				end
				UEE_ANSWER: state_reg <= UEE_IDLE;
				default: state_reg <= UEE_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= !(state_reg == UEE_IDLE &&
				(avs_read_in || avs_write_in));
		end
	end

	assign wr_take = avs_write_in && !avs_waitrequest_out;
	assign full_word = avs_byteenable_in == 4'hf;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_ie_reg <= `UEE_RESET_BYTE;
		end else if (wr_take && avs_address_in == `UEE_OFF_ERR_IE &&
			avs_byteenable_in[0]) begin
			err_ie_reg <= avs_writedata_in[7:0] & `UEE_ERR_IE_MASK;
		end
	end

	assign oversize = rx_done_in && (rx_count_in > bd_count_in);
	always_comb begin
		flag_set = err_event_in & `UEE_ERR_IE_MASK;
		flag_set[`UEE_ERR_DMA] = err_event_in[`UEE_ERR_DMA] | oversize;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			truncate_out <= 1'b0;
		end else begin
			truncate_out <= oversize;
		end
	end

	// whole-word write-one clear; new events win
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_flag_reg <= `UEE_RESET_BYTE;
		end else if (wr_take && avs_address_in == `UEE_OFF_ERR_FLAG &&
			full_word) begin
			err_flag_reg <= (err_flag_reg & ~avs_writedata_in[7:0]) |
				flag_set;
		end else begin
			err_flag_reg <= err_flag_reg | flag_set;
		end
	end

	// per-bit gating of the error flags
	// bit 1 shared by token CRC and frame end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			usb_err_irq_out <= 1'b0;
		end else begin
			usb_err_irq_out <= |(err_flag_reg & err_ie_reg);
		end
	end

	always_comb begin
		for (int i = 0; i < EP_COUNT; i++) begin
			ep_wr_sel[i] = wr_take && avs_byteenable_in[0] &&
				avs_address_in == ep_addr(i);
		end
	end

	always_comb begin
		for (int i = 0; i < EP_COUNT; i++) begin
			stall_sel[i] = stall_evt_in && stall_ep_in == 4'(i);
		end
	end

	// endpoint bytes read-write, reset to zero
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < EP_COUNT; i++) begin
				ep_reg[i] <= `UEE_RESET_BYTE;
			end
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				if (ep_wr_sel[i]) begin
					ep_reg[i] <= avs_writedata_in[7:0] & ep_mask(i, 1'b1);
				end
				// stall event sets status
				// Applied after the write so the event wins
				if (stall_sel[i]) begin
					ep_reg[i][`UEE_BIT_STALLED] <= 1'b1;
				end
			end
		end
	end

	// each endpoint decoded on its own
	for (genvar i = 0; i < EP_COUNT; i++) begin : g_ep
		uee_ep_decode i_uee_ep_decode (
			.ctrl_in(ep_reg[i]),
			.perm_out(perm[i])
		);
	end

	// One process per output vector keeps a single driver each
	// receive enables drive the engine
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_ok_out <= {EP_COUNT{1'b0}};
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				rx_ok_out[i] <= perm[i].rx_ok;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_ok_out <= {EP_COUNT{1'b0}};
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				tx_ok_out[i] <= perm[i].tx_ok;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			setup_ok_out <= {EP_COUNT{1'b0}};
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				setup_ok_out[i] <= perm[i].setup_ok;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hshk_out <= {EP_COUNT{1'b0}};
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				hshk_out[i] <= perm[i].handshake;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lowspeed_direct_out <= 1'b0;
		end else begin
			lowspeed_direct_out <= host_role_in &
				ep_reg[0][`UEE_BIT_LOWSPEED_DIRECT];
		end
	end

	// NAK retry off, host role only
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nak_retry_off_out <= 1'b0;
		end else begin
			nak_retry_off_out <= host_role_in &
				ep_reg[0][`UEE_BIT_RETRY_OFF];
		end
	end

	// Read data registered with the answer
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h0;
		end else if (state_reg == UEE_IDLE && avs_read_in) begin
			if (avs_address_in == `UEE_OFF_ERR_IE) begin
				avs_readdata_out <= {24'h0, err_ie_reg};
			end else if (avs_address_in == `UEE_OFF_ERR_FLAG) begin
				avs_readdata_out <= {24'h0, err_flag_reg};
			end else if (avs_address_in == `UEE_OFF_STATUS) begin
				avs_readdata_out <= {31'h0, host_role_in};
			end else if (is_ep(avs_address_in)) begin
				// host bits hidden outside host role
				avs_readdata_out <= {24'h0,
					ep_reg[avs_address_in[5:2]] &
					ep_mask(int'(avs_address_in[5:2]), host_role_in)};
			end else begin
				avs_readdata_out <= `UEE_BAD_READ;
			end
		end
	end
endmodule

// ==== bench/uee_regs_props.sv ====
// Port checker for the USB error/endpoint register bank
`timescale 1ns/1ps
module uee_regs_props #(
	parameter int EP_COUNT = 16
) (
	input wire logic core_clk_in, // Clock
	input wire logic rst_n_in, // Reset
	input wire logic [7:0] avs_address_in, // Address
	input wire logic avs_read_in, // Read
	input wire logic avs_write_in, // Write
	input wire logic [31:0] avs_readdata_out, // Read data
	input wire logic avs_waitrequest_out, // Wait
	input wire logic host_role_in, // Host role
	input wire logic [10:0] rx_count_in, // Rx bytes
	input wire logic [10:0] bd_count_in, // Room
	input wire logic rx_done_in, // Rx end
	input wire logic usb_err_irq_out, // Irq
	input wire logic lowspeed_direct_out, // Low speed
	input wire logic truncate_out, // Truncate
	input wire logic [EP_COUNT-1:0] rx_ok_out, // Rx ok
	input wire logic [EP_COUNT-1:0] tx_ok_out, // Tx ok
	input wire logic [EP_COUNT-1:0] setup_ok_out // Setup ok
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_ANSWER: assert property ((avs_read_in || avs_write_in)
		&& avs_waitrequest_out |=> !avs_waitrequest_out) else $error("late answer");
	AST_ONE_LOW: assert property (!avs_waitrequest_out
		|=> avs_waitrequest_out) else $error("answer too long");
	AST_EIE_ZERO: assert property (!avs_waitrequest_out && avs_read_in
		&& avs_address_in == 8'h00 |-> !(|(avs_readdata_out & 32'hffffff40)))
		else $error("enable reserved bits set");
	AST_EP_ZERO: assert property (!avs_waitrequest_out && avs_read_in
		&& avs_address_in[7:6] == 2'b01 && avs_address_in[1:0] == 2'b00
		|-> !(|(avs_readdata_out & 32'hffffff20))) else $error("ep reserved set");
	AST_SETUP: assert property (
		!(|(setup_ok_out & ~(rx_ok_out & tx_ok_out)))) else $error("setup leak");
	AST_LOWSPEED_DIRECT: assert property (lowspeed_direct_out
		|-> $past(host_role_in)) else $error("low speed outside host");
	AST_TRUNC: assert property (rx_done_in && rx_count_in > bd_count_in
		|=> truncate_out) else $error("no truncate");
	AST_TRUNC_ONLY: assert property (truncate_out
		|-> $past(rx_done_in) && $past(rx_count_in) > $past(bd_count_in))
		else $error("bad trunc");
	AST_IRQ_FALL: assert property ($fell(usb_err_irq_out)
		|-> $past(avs_write_in, 2) && !$past(avs_waitrequest_out, 2))
		else $error("irq dropped without write");
	AST_EPN_HOST: assert property (!avs_waitrequest_out && avs_read_in
		&& avs_address_in[7:6] == 2'b01 && avs_address_in[5:2] != 4'h0
		&& avs_address_in[1:0] == 2'b00
		|-> avs_readdata_out[7:6] == 2'b00)
		else $error("host bits on other endpoint");
	AST_EP0_DEV: assert property (!avs_waitrequest_out && avs_read_in
		&& avs_address_in == 8'h40 && !$past(host_role_in)
		|-> avs_readdata_out[7:6] == 2'b00)
		else $error("host bits in device role");
endmodule
bind uee_regs uee_regs_props #(.EP_COUNT(EP_COUNT)) i_uee_regs_props (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.host_role_in(host_role_in),
	.rx_count_in(rx_count_in),
	.bd_count_in(bd_count_in),
	.rx_done_in(rx_done_in),
	.usb_err_irq_out(usb_err_irq_out),
	.lowspeed_direct_out(lowspeed_direct_out),
	.truncate_out(truncate_out),
	.rx_ok_out(rx_ok_out),
	.tx_ok_out(tx_ok_out),
	.setup_ok_out(setup_ok_out)
);

// ==== bench/uee_usb_peer.sv ====
// USB-side model: error pulses, endpoint stalls and received packets
`timescale 1ns/1ps
module uee_usb_peer (
	input wire logic clk_in, // Clock
	output logic [7:0] err_out = 8'h00, // Error pulses
	output logic [3:0] ep_out = 4'h0, // Stalled endpoint
	output logic stall_out = 1'b0, // Stall pulse
	output logic [10:0] cnt_out = 11'h0, // Bytes received
	output logic [10:0] room_out = 11'h0, // Descriptor room
	output logic done_out = 1'b0 // Packet end pulse
);
	task err(input logic [7:0] e);
		err_out <= e;
		@(posedge clk_in);
		err_out <= 8'h00;
	endtask
	task stall(input logic [3:0] n);
		ep_out <= n;
		stall_out <= 1'b1;
		@(posedge clk_in);
		stall_out <= 1'b0;
		// Qualifiers are not held past the pulse
		ep_out <= ~n;
	endtask
	task rx(input logic [10:0] c, input logic [10:0] r);
		cnt_out <= c;
		room_out <= r;
		done_out <= 1'b1;
		@(posedge clk_in);
		done_out <= 1'b0;
		cnt_out <= ~c;
		room_out <= ~r;
	endtask
endmodule

// ==== bench/usb_error_enable_and_endpoint_ctrl_tb_top.sv ====
// Self-checking bench for the USB error/endpoint register bank
`timescale 1ns/1ps
`include "uee_defs.svh"
module usb_error_enable_and_endpoint_ctrl_tb_top;
	logic core_clk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0;
	logic avs_write_in = 1'b0, host_role_in = 1'b0, avs_waitrequest_out;
	logic usb_err_irq_out, lowspeed_direct_out, nak_retry_off_out;
	logic truncate_out, stall_evt_in, rx_done_in;
	logic [7:0] avs_address_in = 8'h00, err_event_in;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic [3:0] avs_byteenable_in = 4'h0, stall_ep_in, e;
	logic [10:0] rx_count_in, bd_count_in;
	logic [15:0] rx_ok_out, tx_ok_out, setup_ok_out, hshk_out;
	int fail_count = 0, num_checks = 0;
	uee_regs i_uee_regs (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.host_role_in(host_role_in),
		.err_event_in(err_event_in),
		.stall_ep_in(stall_ep_in),
		.stall_evt_in(stall_evt_in),
		.rx_count_in(rx_count_in),
		.bd_count_in(bd_count_in),
		.rx_done_in(rx_done_in),
		.usb_err_irq_out(usb_err_irq_out),
		.lowspeed_direct_out(lowspeed_direct_out),
		.nak_retry_off_out(nak_retry_off_out),
		.truncate_out(truncate_out),
		.rx_ok_out(rx_ok_out),
		.tx_ok_out(tx_ok_out),
		.setup_ok_out(setup_ok_out),
		.hshk_out(hshk_out)
	);
	uee_usb_peer i_uee_usb_peer(.clk_in(core_clk_in), .err_out(err_event_in),
		.ep_out(stall_ep_in), .stall_out(stall_evt_in), .cnt_out(rx_count_in),
		.room_out(bd_count_in), .done_out(rx_done_in));
	initial begin
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= d;
		avs_byteenable_in <= be;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (n == 20) fail_count++;
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(q, x);
	endtask
	task tk(input int c);
		repeat (c) @(posedge core_clk_in);
	endtask
	task t_reset;
		rd(8'h00, 32'h0);
		for (int n = 0; n < 16; n++) rd(8'h40 + 8'(n * 4), 32'h0);
		$display("reset values done");
	endtask
	task t_irq;
		for (int b = 0; b < 8; b++) begin
			host_role_in <= b[0];
			wr(8'h00, 32'h0);
			i_uee_usb_peer.err(8'h01 << b);
			tk(2);
			chk(usb_err_irq_out, 32'h0);
			wr(8'h00, 32'h1 << b);
			rd(8'h00, 32'hbf & (32'h1 << b));
			chk(usb_err_irq_out, b != 6);
			bus(1'b1, 8'h04, 32'hff, 4'h1);
			tk(2);
			chk(usb_err_irq_out, b != 6);
			wr(8'h04, 32'hff);
			tk(2);
			chk(usb_err_irq_out, 32'h0);
		end
		$display("irq gating done");
	endtask
	task t_ep;
		host_role_in <= 1'b0;
		for (int n = 0; n < 16; n++) begin
			wr(8'h40 + 8'(n * 4), 32'hffff);
			rd(8'h40 + 8'(n * 4), 32'h1f);
			chk(rx_ok_out & tx_ok_out & hshk_out, 32'h1 << n);
			wr(8'h40 + 8'(n * 4), 32'h0);
		end
		for (int i = 0; i < 32; i++) begin
			wr(8'h4c, 32'(i));
			tk(2);
			e = {i[3], i[2], i[3] & i[2] & !i[4], i[0]};
			chk({rx_ok_out[3], tx_ok_out[3], setup_ok_out[3], hshk_out[3]}, e);
		end
		wr(8'h4c, 32'h0);
		$display("endpoint control done");
	endtask
	task t_host;
		wr(8'h40, 32'hc0);
		rd(8'h40, 32'h0);
		chk(lowspeed_direct_out, 32'h0);
		host_role_in <= 1'b1;
		rd(8'h40, 32'hc0);
		chk({lowspeed_direct_out, nak_retry_off_out}, 32'h3);
		wr(8'h40, 32'h40);
		tk(2);
		chk({lowspeed_direct_out, nak_retry_off_out}, 32'h1);
		wr(8'h44, 32'hc0);
		rd(8'h44, 32'h0);
		wr(8'h40, 32'h0);
		$display("host bits done");
	endtask
	task t_misc;
		i_uee_usb_peer.stall(4'h5);
		rd(8'h54, 32'h2);
		wr(8'h54, 32'h0);
		rd(8'h54, 32'h0);
		i_uee_usb_peer.rx(11'h41, 11'h40);
		@(posedge core_clk_in);
		chk(truncate_out, 32'h1);
		rd(8'h04, 32'h20);
		wr(8'h04, 32'hff);
		i_uee_usb_peer.rx(11'h40, 11'h40);
		rd(8'h04, 32'h0);
		rd(8'h3c, `UEE_BAD_READ);
		wr(8'h00, 32'hbf);
		wr(8'h4c, 32'h1f);
		rst_n_in <= 1'b0;
		tk(2);
		rst_n_in <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h4c, 32'h0);
		chk(rx_ok_out | tx_ok_out | hshk_out, 32'h0);
		$display("stall, dma and unmapped done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_reset;
		t_irq;
		t_ep;
		t_host;
		t_misc;
		print_verdict;
	end
	initial begin
		#50000;
		fail_count++;
		print_verdict;
	end
endmodule
